// *** dv/mxu_core_checker.sv ***
// mxu_core_checker: pulse and timing relations watched at the execute core's ports
// assumes it is bound to mxu_core and sees nothing but that module's ports
`default_nettype none
module mxu_core_checker
    import mxu_pkg::*;
#(
    parameter int PC_W = mxu_pkg::MXU_PC_W_DEF,
    parameter int STACK_DEPTH = mxu_pkg::MXU_STACK_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // program memory
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [mxu_pkg::MXU_IW-1:0] prog_data,
    // visible state
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic zero,
    input wire logic dcarry,
    // per-instruction pulses
    input wire logic instr_done,
    input wire logic skip_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    // single clock domain, so clock and reset are declared once
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // the first execute edge is the second one after release; it runs the nop bubble
    a_first_exec: assert property ($rose(rst_n) |-> !instr_done ##1 !instr_done ##1 instr_done)
        else $error("first completion pulse not on the third clock after reset");
    // two clocks per instruction cycle, back to back
    a_done_period: assert property (instr_done |=> !instr_done ##1 instr_done)
        else $error("completion pulse not every second clock");
    // fetch address moves only at an execute edge and then stands a whole cycle
    a_addr_stands: assert property ($changed(prog_addr) |-> instr_done ##1 $stable(prog_addr))
        else $error("fetch address moved outside an execute edge");
    // a whole word executes at once, so the accumulator moves only with a completion
    a_acc_on_exec: assert property ($changed(acc) |-> instr_done)
        else $error("accumulator changed between instructions");
    a_flag_on_exec: assert property ($changed({carry, zero, dcarry}) |-> instr_done)
        else $error("status flags changed between instructions");
    a_skip_pulse: assert property (skip_taken |-> instr_done)
        else $error("skip pulse without completion pulse");
    // skip instructions never write status flags
    a_skip_flags: assert property (skip_taken |-> $stable(carry) && $stable(zero) && $stable(dcarry))
        else $error("status flags changed by a skipping instruction");
    // a skip that wrote the accumulator did so with a zero result
    a_skip_acc: assert property (skip_taken && $changed(acc) |-> acc == 8'h00)
        else $error("skip taken on a nonzero accumulator result");
    // the word after a taken skip is discarded, so the next slot cannot skip
    a_skip_bubble: assert property (skip_taken |=> !skip_taken ##1 !skip_taken)
        else $error("instruction after a taken skip was not discarded");
endmodule // mxu_core_checker
`default_nettype wire

// *** dv/mxu_core_tb.sv ***
// mxu_core_tb: runs short programs through the execute core and checks visible state
// assumes program memory is modelled here as a combinational array; registers start cleared
`default_nettype none
module mxu_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mxu_pkg::*;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 8;
    localparam time SKEW = 2ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [PC_W-1:0] prog_addr;
    logic [MXU_IW-1:0] prog_data;
    logic [7:0] acc;
    logic carry, zero, dcarry, instr_done, skip_taken;
    logic [MXU_IW-1:0] mem [0:(1<<PC_W)-1];
    int mismatches = 0;
    int comparisons = 0;
    int skips;
    int clocks;

    // memory answers at once, well inside the two clocks the core allows
    assign prog_data = mem[prog_addr];
    initial forever #12.5 mclk = ~mclk;

    mxu_core #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) mxu_core_i (
        .mclk(mclk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data), .acc(acc),
        .carry(carry), .zero(zero), .dcarry(dcarry), .instr_done(instr_done), .skip_taken(skip_taken)
    );

    // count taken skips and clocks since release; both cleared by each reset
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            skips <= 0;
            clocks <= 0;
        end
        else
        begin
            clocks <= clocks + 1;
            if (skip_taken === 1'b1)
                skips <= skips + 1;
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic expect_state(input logic [7:0] a, input logic c, input logic z);
        check(acc, a, "acc");
        check({7'h00, carry}, {7'h00, c}, "carry");
        check({7'h00, zero}, {7'h00, z}, "zero");
    endtask

    // empty memory runs as nops; reset is long enough to also serve as a mid-run reset
    task automatic start();
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        #SKEW rst_n = 1'b1;
    endtask

    task automatic clear_mem();
        foreach (mem[i]) mem[i] = MXU_NOP;
    endtask

    // the fetch address reaches p+2 at the edge that executes the word at p
    task automatic after(input int p);
        int n;
        for (n = 0; n < 5000 && prog_addr !== PC_W'(p + 2); n++)
        begin
            @(posedge mclk);
            #SKEW;
        end
        if (n >= 5000)
        begin
            mismatches++;
            $display("wrong value at %0t: address %h never reached", $time, p + 2);
            report_and_stop();
        end
    endtask

    task automatic scen_inc_dec();
        clear_mem();
        mem[0] = 13'h07d0;  // inc r10 to 01
        mem[1] = 13'h05d0;  // dec r10 to 00, skips
        mem[2] = 13'h1855;
        mem[3] = 13'h05d1;  // dec r11 to ff
        mem[4] = 13'h0791;  // inc r11 into acc gives 00, skips
        mem[5] = 13'h1866;
        mem[6] = 13'h07d1;  // inc r11 wraps to 00, skips
        mem[7] = 13'h1877;
        mem[8] = 13'h0590;  // dec r10 into acc gives ff, r10 kept
        mem[9] = 13'h1f01;
        mem[10] = 13'h0c10;  // r10 bit 0 still clear, skips
        mem[11] = 13'h1899;
        start();
        after(8);
        expect_state(8'hff, 1'b0, 1'b0);
        after(11);
        expect_state(8'h00, 1'b1, 1'b1);
        check(8'(skips), 8'h04, "skips");
        // a skipped word keeps its own two-clock slot, so slot 11 still ends on clock 26
        check(8'(clocks), 8'h1a, "skip slot clocks");
    endtask

    task automatic scen_rotate();
        clear_mem();
        mem[0] = 13'h0bd2;  // set bit 7 of r12
        mem[1] = 13'h0a12;  // r12 = 81
        mem[2] = 13'h0612;
        mem[3] = 13'h06d2;  // r12 = 03
        mem[4] = 13'h0652;  // r12 = 81
        mem[5] = 13'h0692;
        mem[6] = 13'h0752;  // r12 = 18
        mem[7] = 13'h0712;
        mem[8] = 13'h0912;  // r12 = 08; clears kept away from 0e and 0f
        mem[9] = 13'h0692;
        start();
        after(2);
        expect_state(8'h40, 1'b1, 1'b0);
        after(5);
        expect_state(8'h03, 1'b1, 1'b0);
        after(7);
        expect_state(8'h81, 1'b1, 1'b0);
        after(9);
        expect_state(8'h11, 1'b0, 1'b0);
    endtask

    task automatic scen_literal();
        clear_mem();
        mem[0] = 13'h18f0;
        mem[1] = 13'h1a3c;
        mem[2] = 13'h190c;
        mem[3] = 13'h1b3c;
        mem[4] = 13'h1d05;  // 05 - 00, no borrow
        mem[5] = 13'h0e93;  // r13 bit 2 clear, no skip
        mem[6] = 13'h0a93;
        mem[7] = 13'h0e93;  // now set, skips
        mem[8] = 13'h18aa;
        mem[9] = 13'h0c93;
        mem[10] = 13'h1ffb;
        start();
        after(2);
        expect_state(8'h3c, 1'b0, 1'b0);
        after(3);
        expect_state(8'h00, 1'b0, 1'b1);
        after(4);
        expect_state(8'h05, 1'b1, 1'b0);
        after(10);
        expect_state(8'h00, 1'b1, 1'b1);
        check({7'h00, dcarry}, 8'h01, "dcarry");
        check(8'(skips), 8'h01, "skips");
    endtask

    // the call sits in page 1, so a dropped page field lands on a wrong-path word
    task automatic scen_call();
        clear_mem();
        mem[12'h005] = 13'h18ee;
        mem[12'h401] = 13'h1005;
        mem[12'h402] = 13'h1f01;  // must run exactly once, after the return
        mem[12'h403] = 13'h1410;
        mem[12'h404] = 13'h18ee;
        mem[12'h405] = 13'h1c3c;
        mem[12'h410] = 13'h1b3d;
        start();
        after(12'h402);
        expect_state(8'h3d, 1'b0, 1'b0);
        // the nop run up to the call fills 2 * 0x401 clocks; call and return cost four clocks each
        check(8'(clocks - 2 * 12'h401), 8'h0c, "call and return clocks");
        after(12'h410);
        expect_state(8'h00, 1'b0, 1'b1);
        // the jump also costs four clocks before its target runs
        check(8'(clocks - 2 * 12'h401), 8'h12, "jump clocks");
    endtask

    initial
    begin
        scen_inc_dec();
        scen_rotate();
        scen_literal();
        scen_call();
        report_and_stop();
    end
endmodule // mxu_core_tb

bind mxu_core mxu_core_checker #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) mxu_core_checker_i (
    .mclk(mclk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data), .acc(acc),
    .carry(carry), .zero(zero), .dcarry(dcarry), .instr_done(instr_done), .skip_taken(skip_taken)
);
`default_nettype wire

// *** inc/mxu_alu_if.sv ***
// mxu_alu_if: operands and results between the execute core and its datapath
// assumes the datapath is purely combinational
`default_nettype none
interface mxu_alu_if;
    import mxu_pkg::*;
    mxu_op_t op;
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] k;
    logic [2:0] bit_sel;
    logic cin;
    logic [7:0] res;
    logic cout;
    logic dc;
    logic z;
    modport core (output op, a, r, k, bit_sel, cin, input res, cout, dc, z);
    modport alu (input op, a, r, k, bit_sel, cin, output res, cout, dc, z);
endinterface : mxu_alu_if
`default_nettype wire

// *** inc/mxu_pkg.sv ***
// mxu_pkg: shared constants, opcode patterns and types for the instruction execute core
// assumes a 13-bit instruction word, 8-bit data path and 6-bit register field
`default_nettype none
package mxu_pkg;
    // widths
    localparam int MXU_IW = 13;
    localparam int MXU_DW = 8;
    localparam int MXU_RAW = 6;
    localparam int MXU_KW = 10;
    localparam int MXU_PC_W_DEF = 12;
    localparam int MXU_STACK_DEF = 8;
    // oscillator periods per instruction cycle
    localparam int MXU_OSC_PER_ICYCLE = 2;
    // reset values
    localparam logic [12:0] MXU_NOP = 13'h0000;
    localparam logic [7:0] MXU_ACC_RST = 8'h00;
    localparam logic [7:0] MXU_RF_RST = 8'h00;
    // field positions
    localparam int MXU_RF_LSB = 0;
    localparam int MXU_BIT_LSB = 6;
    localparam int MXU_K_LSB = 0;
    // register-byte group, decoded from bits 12:6
    localparam logic [6:0] MXU_DEC_ACC = 7'h16;
    localparam logic [6:0] MXU_DEC_REG = 7'h17;
    localparam logic [6:0] MXU_RRC_ACC = 7'h18;
    localparam logic [6:0] MXU_RRC_REG = 7'h19;
    localparam logic [6:0] MXU_RLC_ACC = 7'h1a;
    localparam logic [6:0] MXU_RLC_REG = 7'h1b;
    localparam logic [6:0] MXU_SWP_ACC = 7'h1c;
    localparam logic [6:0] MXU_SWP_REG = 7'h1d;
    localparam logic [6:0] MXU_INC_ACC = 7'h1e;
    localparam logic [6:0] MXU_INC_REG = 7'h1f;
    // bit group, decoded from bits 12:9
    localparam logic [3:0] MXU_BIT_CLR = 4'h4;
    localparam logic [3:0] MXU_BIT_SET = 4'h5;
    localparam logic [3:0] MXU_BIT_SKC = 4'h6;
    localparam logic [3:0] MXU_BIT_SKS = 4'h7;
    // branch group, decoded from bits 12:10
    localparam logic [2:0] MXU_CALL = 3'h4;
    localparam logic [2:0] MXU_JUMP = 3'h5;
    // literal group, decoded from bits 12:8
    localparam logic [4:0] MXU_LIT_MOV = 5'h18;
    localparam logic [4:0] MXU_LIT_OR = 5'h19;
    localparam logic [4:0] MXU_LIT_AND = 5'h1a;
    localparam logic [4:0] MXU_LIT_XOR = 5'h1b;
    localparam logic [4:0] MXU_LIT_RET = 5'h1c;
    localparam logic [4:0] MXU_LIT_SUB = 5'h1d;
    localparam logic [4:0] MXU_LIT_ADD = 5'h1f;

    typedef enum logic [3:0] {
        MXU_OP_NONE, MXU_OP_DEC, MXU_OP_INC, MXU_OP_RRC, MXU_OP_RLC, MXU_OP_SWAP,
        MXU_OP_BCLR, MXU_OP_BSET, MXU_OP_PASSK, MXU_OP_OR, MXU_OP_AND, MXU_OP_XOR,
        MXU_OP_SUBK, MXU_OP_ADDK
    } mxu_op_t;
endpackage : mxu_pkg
`default_nettype wire

// *** rtl/mxu_alu.sv ***
// mxu_alu: combinational datapath for the upper instruction group
// assumes the caller decides which results and flags are kept
`default_nettype none
module mxu_alu (
    mxu_alu_if.alu dp
);
    import mxu_pkg::*;

    // 8-bit add with carry in, returning carry out and sum
    function automatic logic [8:0] mxu_add(input logic [7:0] x, input logic [7:0] y, input logic ci);
        mxu_add = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    endfunction

    logic [8:0] sum;
    logic [4:0] nib;

    // subtraction reuses the adder as k + ~a + 1, so carry means no borrow
    always_comb
    begin
        sum = 9'h000;
        nib = 5'h00;
        dp.res = 8'h00;
        dp.cout = 1'b0;
        dp.dc = 1'b0;
        unique case (dp.op)
            MXU_OP_DEC: dp.res = dp.r - 8'h01;
            MXU_OP_INC: dp.res = dp.r + 8'h01;
            MXU_OP_RRC:
            begin
                dp.res = {dp.cin, dp.r[7:1]};
                dp.cout = dp.r[0];
            end
            MXU_OP_RLC:
            begin
                dp.res = {dp.r[6:0], dp.cin};
                dp.cout = dp.r[7];
            end
            MXU_OP_SWAP: dp.res = {dp.r[3:0], dp.r[7:4]};
            MXU_OP_BCLR: dp.res = dp.r & ~(8'h01 << dp.bit_sel);
            MXU_OP_BSET: dp.res = dp.r | (8'h01 << dp.bit_sel);
            MXU_OP_PASSK: dp.res = dp.k;
            MXU_OP_OR: dp.res = dp.a | dp.k;
            MXU_OP_AND: dp.res = dp.a & dp.k;
            MXU_OP_XOR: dp.res = dp.a ^ dp.k;
            MXU_OP_SUBK:
            begin
                sum = mxu_add(dp.k, ~dp.a, 1'b1);
                nib = {1'b0, dp.k[3:0]} + {1'b0, ~dp.a[3:0]} + 5'h01;
                dp.res = sum[7:0];
                dp.cout = sum[8];
                dp.dc = nib[4];
            end
            MXU_OP_ADDK:
            begin
                sum = mxu_add(dp.k, dp.a, 1'b0);
                nib = {1'b0, dp.k[3:0]} + {1'b0, dp.a[3:0]};
                dp.res = sum[7:0];
                dp.cout = sum[8];
                dp.dc = nib[4];
            end
            MXU_OP_NONE: dp.res = dp.r;
        endcase
    end

    // zero test on the result, used for skips and the zero flag
    assign dp.z = (dp.res == 8'h00);
endmodule // mxu_alu
`default_nettype wire

// *** rtl/mxu_core.sv ***
// mxu_core: fetch, decode and execute for the upper instruction group of an 8-bit core
// assumes program memory returns the word at prog_addr within two mclk periods
`default_nettype none

// Summary of operation
// - decrement to accumulator leaves register, skips on zero result, flags untouched
// - decrement in place writes register back, skips on zero, flags untouched
// - increment to accumulator leaves register, skips on zero result, flags untouched
// - increment in place writes register back, skips on wrap to zero, flags untouched
// - right rotate to accumulator, bit 0 to carry, old carry to bit 7
// - right rotate in place through carry; only carry changes
// - left rotate to accumulator, bit 7 to carry, old carry to bit 0
// - left rotate in place through carry; only carry changes
// - nibble exchange into accumulator or register, flags untouched
// - call pushes next address, loads page plus 10-bit literal; jump same without push
// - literal return loads accumulator and pops program counter, flags untouched
// - each 13-bit instruction is fetched and decoded as one unit
// - one instruction cycle of two clocks, two when the program counter changes
module mxu_core
    import mxu_pkg::*;
#(
    parameter int PC_W = mxu_pkg::MXU_PC_W_DEF,
    parameter int STACK_DEPTH = mxu_pkg::MXU_STACK_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // program memory
    output logic [PC_W-1:0] prog_addr,
    input wire logic [mxu_pkg::MXU_IW-1:0] prog_data,
    // visible state
    output logic [7:0] acc,
    output logic carry,
    output logic zero,
    output logic dcarry,
    // per-instruction pulses
    output logic instr_done,
    output logic skip_taken
);
    import mxu_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int PAGE_W = PC_W - MXU_KW;

    // the page bits must exist and the stack pointer must have at least one bit
    if (PC_W < MXU_KW + 1 || STACK_DEPTH < 2)
    begin : g_bad_param
        $error("mxu_core: PC_W must exceed 10 and STACK_DEPTH must be at least 2");
    end

    mxu_alu_if dp ();

    mxu_alu u_alu (
        .dp(dp)
    );

    logic phase_reg;
    logic [PC_W-1:0] pc_reg;
    logic [MXU_IW-1:0] ir_reg;
    logic [7:0] acc_reg;
    logic carry_reg;
    logic zero_reg;
    logic dc_reg;
    logic done_reg;
    logic skip_reg;
    logic [7:0] rf_reg [64];
    logic [PC_W-1:0] stack_reg [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;

    // decode results
    logic wr_acc;
    logic wr_rf;
    logic wr_c;
    logic wr_z;
    logic wr_dc;
    logic skip_cond;
    logic do_call;
    logic do_jump;
    logic do_ret;
    logic exec;
    logic redirect;
    logic [PC_W-1:0] pc_next;
    logic [5:0] rsel;
    logic [7:0] rval;
    logic [SP_W-1:0] sp_top;

    // the whole 13-bit word is latched and decoded together
    assign rsel = ir_reg[MXU_RF_LSB +: MXU_RAW];
    assign rval = rf_reg[rsel];
    assign exec = phase_reg;
    assign sp_top = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};

    // operand routing to the datapath
    assign dp.a = acc_reg;
    assign dp.r = rval;
    assign dp.k = ir_reg[MXU_K_LSB +: MXU_DW];
    assign dp.bit_sel = ir_reg[MXU_BIT_LSB +: 3];
    assign dp.cin = carry_reg;

    // decode; lower instruction groups fall through as no operation
    always_comb
    begin
        dp.op = MXU_OP_NONE;
        wr_acc = 1'b0;
        wr_rf = 1'b0;
        wr_c = 1'b0;
        wr_z = 1'b0;
        wr_dc = 1'b0;
        skip_cond = 1'b0;
        do_call = 1'b0;
        do_jump = 1'b0;
        do_ret = 1'b0;
        if (ir_reg[12])
        begin
            if (ir_reg[12:10] == MXU_CALL)
                do_call = 1'b1;
            else if (ir_reg[12:10] == MXU_JUMP)
                do_jump = 1'b1;
            else
            begin
                unique case (ir_reg[12:8])
                    MXU_LIT_MOV:
                    begin
                        dp.op = MXU_OP_PASSK;
                        wr_acc = 1'b1;
                    end
                    MXU_LIT_RET:
                    begin
                        dp.op = MXU_OP_PASSK;
                        wr_acc = 1'b1;
                        do_ret = 1'b1;
                    end
                    MXU_LIT_OR, MXU_LIT_AND, MXU_LIT_XOR:
                    begin
                        dp.op = (ir_reg[12:8] == MXU_LIT_OR) ? MXU_OP_OR :
                                (ir_reg[12:8] == MXU_LIT_AND) ? MXU_OP_AND : MXU_OP_XOR;
                        wr_acc = 1'b1;
                        wr_z = 1'b1;
                    end
                    MXU_LIT_SUB, MXU_LIT_ADD:
                    begin
                        dp.op = (ir_reg[12:8] == MXU_LIT_SUB) ? MXU_OP_SUBK : MXU_OP_ADDK;
                        wr_acc = 1'b1;
                        wr_z = 1'b1;
                        wr_c = 1'b1;
                        wr_dc = 1'b1;
                    end
                    default: ; // the unused 0x1e literal slot does nothing
                endcase
            end
        end
        else if (ir_reg[11])
        begin
            // bit group; clearing bits of 0x0e/0x0f is software's concern, not trapped
            unique case (ir_reg[12:9])
                MXU_BIT_CLR:
                begin
                    dp.op = MXU_OP_BCLR;
                    wr_rf = 1'b1;
                end
                MXU_BIT_SET:
                begin
                    dp.op = MXU_OP_BSET;
                    wr_rf = 1'b1;
                end
                MXU_BIT_SKC: skip_cond = ~rval[dp.bit_sel];
                MXU_BIT_SKS: skip_cond = rval[dp.bit_sel];
                default: ;
            endcase
        end
        else
        begin
            unique case (ir_reg[12:6])
                MXU_DEC_ACC, MXU_DEC_REG:
                begin
                    dp.op = MXU_OP_DEC;
                    wr_acc = ~ir_reg[6];
                    wr_rf = ir_reg[6];
                    skip_cond = dp.z;
                end
                MXU_INC_ACC, MXU_INC_REG:
                begin
                    dp.op = MXU_OP_INC;
                    wr_acc = ~ir_reg[6];
                    wr_rf = ir_reg[6];
                    skip_cond = dp.z;
                end
                MXU_RRC_ACC, MXU_RRC_REG:
                begin
                    dp.op = MXU_OP_RRC;
                    wr_acc = ~ir_reg[6];
                    wr_rf = ir_reg[6];
                    wr_c = 1'b1;
                end
                MXU_RLC_ACC, MXU_RLC_REG:
                begin
                    dp.op = MXU_OP_RLC;
                    wr_acc = ~ir_reg[6];
                    wr_rf = ir_reg[6];
                    wr_c = 1'b1;
                end
                MXU_SWP_ACC, MXU_SWP_REG:
                begin
                    dp.op = MXU_OP_SWAP;
                    wr_acc = ~ir_reg[6];
                    wr_rf = ir_reg[6];
                end
                default: ;
            endcase
        end
    end

    // any change of flow costs one bubble; the page comes from the current counter
    assign redirect = do_call | do_jump | do_ret | skip_cond;
    always_comb
    begin
        pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
        if (do_call | do_jump)
            pc_next = {pc_reg[PC_W-1 -: PAGE_W], ir_reg[MXU_KW-1:0]};
        else if (do_ret)
            pc_next = stack_reg[sp_top];
    end

    // two mclk periods per instruction cycle: fetch settles, then execute
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end

    // fetch pipeline; a taken skip turns the fetched word into a bubble
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_reg <= '0;
            ir_reg <= MXU_NOP;
        end
        else if (exec)
        begin
            pc_reg <= pc_next;
            ir_reg <= redirect ? MXU_NOP : prog_data;
        end
    end

    // accumulator and flags; skip and swap ops leave flags alone
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= MXU_ACC_RST;
            carry_reg <= 1'b0;
            zero_reg <= 1'b0;
            dc_reg <= 1'b0;
        end
        else if (exec)
        begin
            if (wr_acc)
                acc_reg <= dp.res;
            if (wr_c)
                carry_reg <= dp.cout;
            if (wr_z)
                zero_reg <= dp.z;
            if (wr_dc)
                dc_reg <= dp.dc;
        end
    end

    // register file; reset clears it so simulation starts from known data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 64; i++)
                rf_reg[i] <= MXU_RF_RST;
        end
        else if (exec && wr_rf)
            rf_reg[rsel] <= dp.res;
    end

    // return stack wraps silently on overflow, as small cores do; no trap
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sp_reg <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_reg[i] <= '0;
        end
        else if (exec)
        begin
            if (do_call)
            begin
                stack_reg[sp_reg] <= pc_reg;
                sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
            end
            else if (do_ret)
                sp_reg <= sp_top;
        end
    end

    // one-cycle pulses marking the end of each instruction cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
        end
        else
        begin
            done_reg <= exec;
            skip_reg <= exec & skip_cond;
        end
    end

    assign prog_addr = pc_reg;
    assign acc = acc_reg;
    assign carry = carry_reg;
    assign zero = zero_reg;
    assign dcarry = dc_reg;
    assign instr_done = done_reg;
    assign skip_taken = skip_reg;
endmodule // mxu_core
`default_nettype wire
